/* rtl/fsp_pkg.sv */
package fsp_pkg;

   // ---------------------------------------------------------------
   // Host command register map (word indices on the plain port)
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_ADDR   = 4'h1;
   localparam logic [3:0] REG_DATA   = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   localparam logic [3:0] REG_RDATA  = 4'h4;

   // CTRL field positions (a write with a nonzero op starts a job)
   localparam int CTRL_OP_LSB  = 0;  // 3-bit op code
   localparam int CTRL_HV_BIT  = 4;  // Reset pin to high voltage
   localparam int CTRL_WP_BIT  = 5;  // Write-protect pin level
   localparam int CTRL_SR_BIT  = 6;  // Secured-region mode wanted

   // STATUS field positions
   localparam int STS_BUSY_BIT = 0;
   localparam int STS_REF_BIT  = 1;  // Job refused
   localparam int STS_SR_BIT   = 2;  // Secured region mapped
   localparam int STS_GRP_LSB  = 8;  // Group of last address, 5 bits

   // Unlock, program, erase, reset and secured-region command words
   localparam logic [21:0] UNLK_ADDR1 = 22'h000555;
   localparam logic [21:0] UNLK_ADDR2 = 22'h0002aa;
   localparam logic [15:0] UNLK_DATA1 = 16'h00aa;
   localparam logic [15:0] UNLK_DATA2 = 16'h0055;
   localparam logic [15:0] CMD_PROG   = 16'h00a0;
   localparam logic [15:0] CMD_ERASE1 = 16'h0080;
   localparam logic [15:0] CMD_SECERS = 16'h0030;
   localparam logic [15:0] CMD_SR_IN  = 16'h0088;
   localparam logic [15:0] CMD_SR_OUT = 16'h0090;
   localparam logic [15:0] CMD_SR_OX  = 16'h0000;
   localparam logic [15:0] CMD_RESET  = 16'h00f0;

   // Group select bits of the word address
   localparam int GRP_MSB = 21;
   localparam int GRP_LSB = 17;
   localparam logic [4:0] GRP_FIRST = 5'h00;
   localparam logic [4:0] GRP_LAST  = 5'h1f;

   // Bus timing: clock period, write strobe low time and read access
   localparam int CLK_NS    = 10;
   localparam int TWP_NS    = 35;
   localparam int TACC_NS   = 90;
   localparam int TWP_CYC   = (TWP_NS + CLK_NS - 1) / CLK_NS;
   localparam int TACC_CYC  = (TACC_NS + CLK_NS - 1) / CLK_NS;

   typedef enum logic [2:0] {
      OP_NONE, OP_READ, OP_PROG, OP_SECERASE, OP_SR_ENTER,
      OP_SR_EXIT, OP_RESET
   } fsp_op_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_SETUP, ST_STROBE, ST_GAP, ST_READ, ST_DONE
   } fsp_state_t;

   // Flash pins as seen from the controller
   typedef struct packed {
      logic [21:0] addr;
      logic [15:0] dout;
      logic        doutEn;
      logic        ceN;
      logic        oeN;
      logic        weN;
      logic        wpN;
      logic        rstHv;
   } fsp_pins_t;

   typedef struct packed {
      fsp_state_t  state;
      fsp_op_t     op;
      logic [2:0]  step;
      logic [3:0]  cnt;
      logic [21:0] addr;
      logic [15:0] data;
      logic [15:0] rdata;
      logic [31:0] rdOut;
      logic        refused;
      logic        srMode;
      logic        hvReq;
      logic        wpLevel;
      logic        srWanted;
      logic [15:0] dqS1;
      logic [15:0] dqS2;
      logic [15:0] dqS3;
      fsp_pins_t   pins;
   } fsp_state_s_t;

endpackage

/* rtl/fsp_host_ctrl.sv */
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module fsp_host_ctrl #(
   parameter bit WP_GUARDS_TOP = 1'b0  // Guarded sector at top of array
) (
   input  wire logic                clk,      // 100 MHz clock
   input  wire logic                rst_n,    // Async reset, active low
   input  wire logic [3:0]          regAddr,  // Register word index
   input  wire logic [31:0]         regWdata, // Register write data
   input  wire logic                regWr,    // Write strobe
   input  wire logic                regRd,    // Read strobe
   output logic      [31:0]         regRdata, // Read data, next cycle
   input  wire logic [15:0]         dqIn,     // Flash data pins in
   output fsp_pkg::fsp_pins_t       flash,    // Flash pin drive
   output logic                     groupLocked // Address in guarded sector while write-protect low
);

   fsp_pkg::fsp_state_s_t s_r, s_nxt;
   logic [4:0]  grpSel;
   logic        guarded;
   logic        wrCmd;
   logic [21:0] seqAddr;
   logic [15:0] seqData;
   logic [2:0]  seqLen;

   initial begin
      if (fsp_pkg::TWP_CYC < 1 || fsp_pkg::TWP_CYC > 15)
         $error("Write strobe width out of counter range");
   end

   // ---------------------------------------------------------------
   // Command sequences
   // ---------------------------------------------------------------
   assign grpSel = s_r.addr[fsp_pkg::GRP_MSB:fsp_pkg::GRP_LSB];
   assign guarded = (grpSel == (WP_GUARDS_TOP ? fsp_pkg::GRP_LAST
                                              : fsp_pkg::GRP_FIRST));
   assign groupLocked = guarded & ~s_r.wpLevel;
   assign wrCmd = (s_r.op == fsp_pkg::OP_PROG)
                | (s_r.op == fsp_pkg::OP_SECERASE);

   always_comb begin
      seqLen  = 3'd1;
      seqAddr = fsp_pkg::UNLK_ADDR1;
      seqData = fsp_pkg::CMD_RESET;
      case (s_r.op)
         fsp_pkg::OP_PROG, fsp_pkg::OP_SR_ENTER: begin
            seqLen = (s_r.op == fsp_pkg::OP_PROG) ? 3'd4 : 3'd3;
            case (s_r.step)
               3'd0: seqData = fsp_pkg::UNLK_DATA1;
               3'd1: begin
                  seqAddr = fsp_pkg::UNLK_ADDR2;
                  seqData = fsp_pkg::UNLK_DATA2;
               end
               3'd2: seqData = (s_r.op == fsp_pkg::OP_PROG)
                               ? fsp_pkg::CMD_PROG : fsp_pkg::CMD_SR_IN;
               default: begin
                  seqAddr = s_r.addr;
                  seqData = s_r.data;
               end
            endcase
         end
         fsp_pkg::OP_SECERASE: begin
            seqLen = 3'd6;
            case (s_r.step)
               3'd0, 3'd3: seqData = fsp_pkg::UNLK_DATA1;
               3'd1, 3'd4: begin
                  seqAddr = fsp_pkg::UNLK_ADDR2;
                  seqData = fsp_pkg::UNLK_DATA2;
               end
               3'd2: seqData = fsp_pkg::CMD_ERASE1;
               default: begin
                  seqAddr = s_r.addr;
                  seqData = fsp_pkg::CMD_SECERS;
               end
            endcase
         end
         fsp_pkg::OP_SR_EXIT: begin
            seqLen = 3'd4;
            case (s_r.step)
               3'd0: seqData = fsp_pkg::UNLK_DATA1;
               3'd1: begin
                  seqAddr = fsp_pkg::UNLK_ADDR2;
                  seqData = fsp_pkg::UNLK_DATA2;
               end
               3'd2: seqData = fsp_pkg::CMD_SR_OUT;
               default: seqData = fsp_pkg::CMD_SR_OX;
            endcase
         end
         default: begin
            seqLen  = 3'd1;
            seqAddr = fsp_pkg::UNLK_ADDR1;
            seqData = fsp_pkg::CMD_RESET;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Sequencer and register file
   // ---------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.dqS1 = dqIn;
      s_nxt.dqS2 = s_r.dqS1;
      s_nxt.dqS3 = s_r.dqS2;
      s_nxt.rdOut = 32'h0000_0000;
      s_nxt.pins.wpN  = s_r.wpLevel;
      s_nxt.pins.rstHv = s_r.hvReq;
      if (regRd) begin
         case (regAddr)
            fsp_pkg::REG_CTRL:
               s_nxt.rdOut = {25'h0, s_r.srWanted, s_r.wpLevel, s_r.hvReq,
                              1'b0, s_r.op};
            fsp_pkg::REG_ADDR:   s_nxt.rdOut = {10'h0, s_r.addr};
            fsp_pkg::REG_DATA:   s_nxt.rdOut = {16'h0, s_r.data};
            fsp_pkg::REG_STATUS:
               s_nxt.rdOut = {19'h0, grpSel, 5'h0, s_r.srMode, s_r.refused,
                              (s_r.state != fsp_pkg::ST_IDLE)};
            fsp_pkg::REG_RDATA:  s_nxt.rdOut = {16'h0, s_r.rdata};
            default:             s_nxt.rdOut = 32'h0000_0000;
         endcase
      end
      if (regWr && s_r.state == fsp_pkg::ST_IDLE) begin
         case (regAddr)
            fsp_pkg::REG_ADDR: s_nxt.addr = regWdata[21:0];
            fsp_pkg::REG_DATA: s_nxt.data = regWdata[15:0];
            fsp_pkg::REG_CTRL: begin
               s_nxt.hvReq    = regWdata[fsp_pkg::CTRL_HV_BIT];
               s_nxt.wpLevel  = regWdata[fsp_pkg::CTRL_WP_BIT];
               s_nxt.srWanted = regWdata[fsp_pkg::CTRL_SR_BIT];
               // Pins move with the flags, so lock flag never leads pin
               s_nxt.pins.wpN   = regWdata[fsp_pkg::CTRL_WP_BIT];
               s_nxt.pins.rstHv = regWdata[fsp_pkg::CTRL_HV_BIT];
               // No group unprotect op, so protect-first order holds
               s_nxt.op = fsp_pkg::fsp_op_t'(regWdata[2:0]);
               if (regWdata[2:0] != 3'd0) begin
                  s_nxt.state   = fsp_pkg::ST_SETUP;
                  s_nxt.step    = 3'd0;
                  s_nxt.refused = 1'b0;
               end
            end
            default: ;
         endcase
      end
      case (s_r.state)
         fsp_pkg::ST_IDLE: ;
         fsp_pkg::ST_SETUP: begin
            // Guarded sector is not bothered while write-protect low, outside secured-region mode
            if (wrCmd && groupLocked && !s_r.srMode) begin
               s_nxt.refused = 1'b1;
               s_nxt.state   = fsp_pkg::ST_DONE;
            end else if (s_r.op == fsp_pkg::OP_READ) begin
               s_nxt.pins.addr = s_r.addr;
               s_nxt.pins.ceN  = 1'b0;
               s_nxt.pins.oeN  = 1'b0;
               s_nxt.pins.doutEn = 1'b0;
               s_nxt.cnt   = 4'(fsp_pkg::TACC_CYC);
               s_nxt.state = fsp_pkg::ST_READ;
            end else begin
               // Enable held high before strobes drop
               s_nxt.pins.oeN  = 1'b1;
               s_nxt.pins.addr = seqAddr;
               s_nxt.pins.dout = seqData;
               s_nxt.pins.doutEn = 1'b1;
               s_nxt.pins.ceN  = 1'b0;
               s_nxt.pins.weN  = 1'b0;
               // Width well above glitch filter
               s_nxt.cnt   = 4'(fsp_pkg::TWP_CYC);
               s_nxt.state = fsp_pkg::ST_STROBE;
            end
         end
         fsp_pkg::ST_STROBE: begin
            if (s_r.cnt > 4'h1) s_nxt.cnt = s_r.cnt - 4'h1;
            else begin
               s_nxt.pins.weN = 1'b1;
               s_nxt.pins.ceN = 1'b1;
               s_nxt.state = fsp_pkg::ST_GAP;
            end
         end
         fsp_pkg::ST_GAP: begin
            s_nxt.pins.doutEn = 1'b0;
            if (s_r.step + 3'd1 >= seqLen) s_nxt.state = fsp_pkg::ST_DONE;
            else begin
               s_nxt.step  = s_r.step + 3'd1;
               s_nxt.state = fsp_pkg::ST_SETUP;
            end
            if (s_r.step + 3'd1 >= seqLen) begin
               if (s_r.op == fsp_pkg::OP_SR_ENTER) s_nxt.srMode = 1'b1;
               // Reset command keeps the mapping; only exit or rst_n low leaves it
               if (s_r.op == fsp_pkg::OP_SR_EXIT) s_nxt.srMode = 1'b0;
            end
         end
         fsp_pkg::ST_READ: begin
            if (s_r.cnt > 4'h1) s_nxt.cnt = s_r.cnt - 4'h1;
            else begin
               // Data sampled at end of access only if two late stages agree
               if (s_r.dqS2 == s_r.dqS3) s_nxt.rdata = s_r.dqS3;
               s_nxt.pins.oeN = 1'b1;
               s_nxt.pins.ceN = 1'b1;
               s_nxt.state = fsp_pkg::ST_DONE;
            end
         end
         fsp_pkg::ST_DONE: s_nxt.state = fsp_pkg::ST_IDLE;
         default: s_nxt.state = fsp_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // Pins idle with strobes high so no command is taken
         s_r <= '{state: fsp_pkg::ST_IDLE, op: fsp_pkg::OP_NONE,
                  pins: '{addr: 22'h0, dout: 16'h0, doutEn: 1'b0,
                          ceN: 1'b1, oeN: 1'b1, weN: 1'b1, wpN: 1'b1,
                          rstHv: 1'b0},
                  wpLevel: 1'b1, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign regRdata = s_r.rdOut;
   assign flash    = s_r.pins;

endmodule

/* test/fsp_host_ctrl_sva.sv */
`timescale 1ns/10ps
module fsp_host_ctrl_sva (
   input wire logic          clk,        // Clock
   input wire logic          rst_n,      // Reset, active low
   input wire logic [3:0]    regAddr,    // Register index
   input wire logic [31:0]   regWdata,   // Write data
   input wire logic          regWr,      // Write strobe
   input wire logic          regRd,      // Read strobe
   input wire logic [31:0]   regRdata,   // Read data
   input wire logic [15:0]   dqIn,       // Flash data in
   input wire fsp_pkg::fsp_pins_t flash, // Flash pins
   input wire logic          groupLocked // Guarded target
);
   // ----------
   // Pin and read data checks
   // ----------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_WRI: assert property (!flash.weN |-> !flash.ceN && flash.oeN)
      else $error("write strobe without select");
   AST_OEW: assert property (!flash.oeN |-> !flash.ceN && flash.weN)
      else $error("output enable during write");
   AST_WEW: assert property ($fell(flash.weN) |-> (!flash.weN)[*4])
      else $error("write pulse too short");
   AST_WEH: assert property ($rose(flash.weN) |=> flash.weN)
      else $error("no gap after write pulse");
   AST_STB: assert property (!flash.weN && !$past(flash.weN)
      |-> $stable(flash.addr) && $stable(flash.dout))
      else $error("address or data moved in pulse");
   AST_DEN: assert property (flash.doutEn |-> flash.oeN)
      else $error("data driven while flash drives");
   AST_GLK: assert property (groupLocked |-> !flash.wpN)
      else $error("lock flag without write protect");
   AST_HVC: assert property ($changed(flash.rstHv) |-> flash.weN)
      else $error("high voltage moved in pulse");
   AST_RDZ: assert property (!regRd |=> regRdata == 32'h0)
      else $error("read data outside read slot");
endmodule
bind fsp_host_ctrl fsp_host_ctrl_sva u_sva (.clk(clk), .rst_n(rst_n),
   .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
   .regRdata(regRdata), .dqIn(dqIn), .flash(flash),
   .groupLocked(groupLocked));

/* test/fsp_flash_model.sv */
`timescale 1ns/10ps
module fsp_flash_model #(
   parameter bit FACTORY_LOCK = 1'b1 // Secured region locked
) (
   input wire logic           resetN, // Board reset, active low
   input wire fsp_pkg::fsp_pins_t p,  // Pins from controller
   output logic [15:0]        dq      // Data to controller
);
   // ------------
   // Device model
   // ------------
   logic [31:0] grpProt = 32'h0;
   logic [15:0] mem [logic [21:0]];
   logic [2:0]  seq = 3'h0;
   int          nErase = 0;
   logic [21:0] eA;
   logic        srMap = 1'b0;
   logic [15:0] last = 16'h0;
   int          nProg = 0;
   logic [21:0] pA, a;
   logic [15:0] pD, d;
   logic        sel;
   realtime     tLow;
   function automatic logic blocked(input logic [21:0] x);
      // A customer lock would answer the same way, for good
      if (srMap && x[21:15] == 7'h0)
         return FACTORY_LOCK;
      if (x[21:15] == 7'h0 && !p.wpN)
         return 1'b1;
      return grpProt[x[21:17]] && !p.rstHv;
   endfunction
   function automatic logic [15:0] rdv(input logic [21:0] x);
      if (srMap && x[21:15] == 7'h0)
         return x[6:0] < 7'h8 ? {9'h0a5, x[6:0]} : {8'h0, FACTORY_LOCK, 7'h0};
      return mem.exists(x) ? mem[x] : x[15:0] ^ 16'h3c3c;
   endfunction
   always @(negedge resetN) begin
      srMap = 1'b0;
      seq = 3'h0;
   end
   // Pins settle in the same step as the strobe, so sample a little later
   always @(negedge p.weN) begin
      tLow = $realtime;
      #1;
      a = p.addr;
      d = p.dout;
      sel = !p.ceN && p.oeN;
   end
   always @(posedge p.weN) begin
      // Board reset low stands in for supply lockout
      if (resetN && sel && $realtime - tLow >= 5.0) begin
         if (d == 16'h00f0) seq = 3'h0;
         else case (seq)
            3'h0, 3'h4:
               seq = (a == 22'h555 && d == 16'h00aa) ? seq + 3'h1 : 3'h0;
            3'h1, 3'h5:
               seq = (a == 22'h2aa && d == 16'h0055) ? seq + 3'h1 : 3'h0;
            3'h2: begin
               seq = d == 16'h00a0 ? 3'h3 : 3'h0;
               if (d == 16'h0080) seq = 3'h4;
               if (d == 16'h0088) srMap = 1'b1;
               if (d == 16'h0090) seq = 3'h3;
            end
            3'h6: begin
               seq = 3'h0;
               if (d == 16'h0030 && !blocked(a)) begin
                  nErase++;
                  eA = a;
               end
            end
            default: begin
               seq = 3'h0;
               if (d == 16'h0000 && srMap) srMap = 1'b0;
               else if (!blocked(a)) begin
                  nProg++;
                  pA = a;
                  pD = d;
                  mem[a] = d;
               end
            end
         endcase
      end
   end
   // Deselected bus shows the complement of the last read, never a stale match
   always @(p.ceN, p.oeN, p.addr) begin
      if (!p.ceN && !p.oeN) last = rdv(p.addr);
      dq = (!p.ceN && !p.oeN) ? last : ~last;
   end
endmodule

/* test/fsp_host_ctrl_bench.sv */
`timescale 1ns/10ps
module fsp_host_ctrl_bench;
   logic clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, gl;
   logic [3:0]  regAddr = 4'h0;
   logic [31:0] regWdata = 32'h0, regRdata, r;
   logic [15:0] dqIn, mdq, dt;
   logic [21:0] ad;
   fsp_pkg::fsp_pins_t flash;
   int n_mismatch = 0, total_checks = 0, expN = 0, s;
   always #5 clk = ~clk;
   assign dqIn = flash.doutEn ? flash.dout : mdq;
   fsp_host_ctrl #(.WP_GUARDS_TOP(1'b0)) dut (.clk(clk), .rst_n(rst_n),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .dqIn(dqIn), .flash(flash), .groupLocked(gl));
   fsp_flash_model #(.FACTORY_LOCK(1'b1)) fm (.resetN(rst_n), .p(flash),
      .dq(mdq));
   // -------------
   // Bus and check
   // -------------
   task automatic chk(input logic ok, input string m);
      total_checks++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= v;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 r = regRdata;
   endtask
   task automatic job(input logic [2:0] op, input logic wp, hv);
      int i;
      wr(fsp_pkg::REG_CTRL, {25'h0, 1'b0, wp, hv, 1'b0, op});
      i = 0;
      r = 32'h1;
      while (r[0] !== 1'b0 && i < 100) begin
         rd(fsp_pkg::REG_STATUS);
         i++;
      end
      chk(i < 100, "job hangs");
   endtask
   task automatic pg(input logic [21:0] a, input logic [15:0] v,
                     input logic [2:0] op, input logic wp, hv);
      wr(fsp_pkg::REG_ADDR, {10'h0, a});
      wr(fsp_pkg::REG_DATA, {16'h0, v});
      job(op, wp, hv);
   endtask
   function automatic logic [15:0] exp_rd(input logic [21:0] a, logic sr);
      if (sr) return a[6:0] < 7'h8 ? {9'h0a5, a[6:0]} : 16'h0080;
      return a[15:0] ^ 16'h3c3c;
   endfunction
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      n_mismatch++;
      end_sim;
   end
   initial begin
      s = $urandom(32'h319b6fc8);
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      chk(flash.weN === 1'b1 && flash.rstHv === 1'b0, "idle pins");
      rd(4'hf);
      chk(r === 32'h0, "unmapped read");
      $display("reset test done");
      repeat (6) begin
         ad = {5'($urandom_range(31, 1)), 17'($urandom)};
         dt = 16'($urandom);
         pg(ad, dt, 3'h2, 1'b1, 1'b0);
         expN++;
         chk(fm.nProg === expN && fm.pA === ad && fm.pD === dt, "prog");
         chk(r[12:8] === ad[21:17], "group field");
         pg(ad, 16'h0, 3'h1, 1'b1, 1'b0);
         rd(fsp_pkg::REG_RDATA);
         chk(r[15:0] === dt, "read back");
      end
      $display("random test done");
      for (int op = 2; op < 4; op++) begin
         pg(22'h000100, 16'h1111, 3'(op), 1'b0, 1'b0);
         chk(r[1] === 1'b1 && gl === 1'b1 && fm.nProg === expN, "guard");
      end
      pg(22'h040000, 16'h0, 3'h3, 1'b1, 1'b0);
      chk(r[1] === 1'b0 && fm.nErase === 1, "erase");
      chk(fm.eA === 22'h040000, "erase address");
      pg(22'h3f0100, 16'h2222, 3'h2, 1'b0, 1'b0);
      expN++;
      chk(r[1] === 1'b0 && fm.nProg === expN, "top group free");
      fm.grpProt[0] = 1'b1;
      pg(22'h000200, 16'h3333, 3'h2, 1'b1, 1'b0);
      chk(r[1] === 1'b0 && fm.nProg === expN, "stored protect");
      pg(22'h000200, 16'h3333, 3'h2, 1'b1, 1'b1);
      expN++;
      chk(flash.rstHv === 1'b1 && fm.nProg === expN, "temp open");
      pg(22'h000300, 16'h4444, 3'h2, 1'b1, 1'b0);
      chk(fm.nProg === expN, "protect back");
      pg(22'h000300, 16'h4444, 3'h2, 1'b0, 1'b1);
      chk(r[1] === 1'b1 && fm.nProg === expN, "hv with guard");
      $display("protect test done");
      job(3'h4, 1'b1, 1'b0);
      chk(r[2] === 1'b1 && fm.srMap === 1'b1, "enter secured");
      foreach (ad[i]) if (i < 2) begin
         pg(i ? 22'h40 : 22'h3, 16'h0, 3'h1, 1'b1, 1'b0);
         rd(fsp_pkg::REG_RDATA);
         chk(r[15:0] === exp_rd(i ? 22'h40 : 22'h3, 1'b1), "secured");
      end
      pg(22'h000005, 16'h5555, 3'h2, 1'b0, 1'b0);
      chk(r[1] === 1'b0 && fm.nProg === expN, "factory lock");
      job(3'h5, 1'b1, 1'b0);
      chk(r[2] === 1'b0 && fm.srMap === 1'b0, "exit secured");
      pg(22'h3, 16'h0, 3'h1, 1'b1, 1'b0);
      rd(fsp_pkg::REG_RDATA);
      chk(r[15:0] === exp_rd(22'h3, 1'b0), "array again");
      job(3'h4, 1'b1, 1'b0);
      job(3'h6, 1'b1, 1'b0);
      chk(r[2] === 1'b1 && fm.srMap === 1'b1, "reset cmd keeps map");
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(fsp_pkg::REG_STATUS);
      chk(r[2] === 1'b0 && fm.srMap === 1'b0, "reset leaves");
      $display("secured test done");
      end_sim;
   end
endmodule
